// file: core/pfc_pkg.sv
// Behaviour
// - program is three unlock writes then address and data write.
// - host only polls status while an internal operation runs.
// - sector erase is six writes, last carries 30h and sector address.
// - chip erase is six writes ending 10h at 5555h; all ones.
// - on apparent completion host re-reads twice; both valid means done.
// - unlock writes aah@5555h, 55h@2aaah, then command at 5555h.
package pfc_pkg;
    localparam int ADDR_W = 19;
    localparam logic [18:0] ADDR_UNLOCK1 = 19'h05555;
    localparam logic [18:0] ADDR_UNLOCK2 = 19'h02aaa;
    localparam logic [7:0] DATA_UNLOCK1 = 8'haa;
    localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam int SECTOR_LSB = 12;
    localparam int CLK_PERIOD_NS = 5;
    // write pulse and read access phase lengths
    localparam int STROBE_NS = 40;
    localparam int ACCESS_NS = 75;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_US = 20;
    localparam int PROG_MAX_CYC = PROG_MAX_US * 1000 / CLK_PERIOD_NS;
    // wide enough for the default poll limit of forty million
    localparam int CNT_W = 26;
    localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0000000;

    typedef enum logic [1:0] {
        PFC_OP_PROGRAM,
        PFC_OP_SECTOR_ERASE,
        PFC_OP_CHIP_ERASE,
        PFC_OP_READ
    } pfc_op_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [18:0] addr;
        logic [7:0] dout;
        logic dout_en;
    } pfc_pins_t;

    typedef struct packed {
        logic valid;
        pfc_op_t op;
        logic [18:0] addr;
        logic [7:0] data;
    } pfc_req_t;

    typedef struct packed {
        logic done;
        logic error;
        logic [7:0] rdata;
    } pfc_rsp_t;
endpackage

// file: core/pfc_host.sv
`timescale 1ns/1ps
module pfc_host #(
    parameter int POLL_LIMIT = 200000000 / 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pfc_pkg::pfc_req_t req,
    output logic req_ready,
    output pfc_pkg::pfc_rsp_t rsp,
    output pfc_pkg::pfc_pins_t pins,
    input wire logic [7:0] data_bus_in
);
    typedef enum logic [2:0] {
        PFC_IDLE, PFC_SETUP, PFC_STROBE, PFC_GAP, PFC_READ, PFC_EVAL,
        PFC_DONE
    } pfc_state_t;

    typedef struct packed {
        pfc_state_t st;
        pfc_pkg::pfc_op_t op;
        logic [18:0] addr;
        logic [7:0] data;
        logic [2:0] step;
        logic [2:0] nsteps;
        logic [pfc_pkg::CNT_W-1:0] cnt;
        logic [pfc_pkg::CNT_W-1:0] wait_cnt;
        logic polling;
        logic [7:0] prev;
        logic have_prev;
        logic [1:0] confirm;
        logic ready;
        pfc_pkg::pfc_rsp_t rsp;
        pfc_pkg::pfc_pins_t pins;
    } pfc_host_state_t;

    pfc_host_state_t s_reg;
    pfc_host_state_t s_next;

    logic [18:0] cyc_addr;
    logic [7:0] cyc_data;
    logic toggling;
    logic bit7_ok;

    ////////////////////////////////////////////////////////////////////////
    // sequence table: unlock pairs then the command cycle
    always_comb begin
        cyc_addr = pfc_pkg::ADDR_UNLOCK1;
        cyc_data = pfc_pkg::DATA_UNLOCK1;
        unique case (s_reg.step)
            3'h0: begin
                cyc_addr = pfc_pkg::ADDR_UNLOCK1;
                cyc_data = pfc_pkg::DATA_UNLOCK1;
            end
            3'h3: begin
                // program ends here; erases repeat the first unlock
                if (s_reg.op == pfc_pkg::PFC_OP_PROGRAM) begin
                    cyc_addr = s_reg.addr;
                    cyc_data = s_reg.data;
                end else begin
                    cyc_addr = pfc_pkg::ADDR_UNLOCK1;
                    cyc_data = pfc_pkg::DATA_UNLOCK1;
                end
            end
            3'h1, 3'h4: begin
                cyc_addr = pfc_pkg::ADDR_UNLOCK2;
                cyc_data = pfc_pkg::DATA_UNLOCK2;
            end
            3'h2: begin
                cyc_addr = pfc_pkg::ADDR_UNLOCK1;
                cyc_data = (s_reg.op == pfc_pkg::PFC_OP_PROGRAM) ?
                    pfc_pkg::CMD_PROGRAM : pfc_pkg::CMD_ERASE_SETUP;
            end
            default: begin
                if (s_reg.op == pfc_pkg::PFC_OP_SECTOR_ERASE) begin
                    // low bits zero; only the sector field matters
                    cyc_addr = {s_reg.addr[18:pfc_pkg::SECTOR_LSB],
                        12'h000};
                    cyc_data = pfc_pkg::CMD_SECTOR_ERASE;
                end else begin
                    cyc_addr = pfc_pkg::ADDR_UNLOCK1;
                    cyc_data = pfc_pkg::CMD_CHIP_ERASE;
                end
            end
        endcase
    end

    // bit 6 moving between two reads means still busy
    assign toggling = (data_bus_in[6] ^ s_reg.prev[6]) & s_reg.have_prev;
    // program expects true bit 7, erase expects one
    assign bit7_ok = (s_reg.op == pfc_pkg::PFC_OP_PROGRAM) ?
        (data_bus_in[7] == s_reg.data[7]) : data_bus_in[7];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.rsp.done = 1'b0;
        s_next.rsp.error = 1'b0;
        unique case (s_reg.st)
            PFC_IDLE: begin
                s_next.ready = 1'b1;
                if (req.valid && s_reg.ready) begin
                    s_next.ready = 1'b0;
                    s_next.op = req.op;
                    s_next.addr = req.addr;
                    s_next.data = req.data;
                    s_next.step = 3'h0;
                    s_next.have_prev = 1'b0;
                    s_next.confirm = 2'h0;
                    s_next.wait_cnt = pfc_pkg::CNT_ZERO;
                    s_next.polling = (req.op != pfc_pkg::PFC_OP_READ);
                    s_next.nsteps = (req.op == pfc_pkg::PFC_OP_PROGRAM) ?
                        3'h3 : 3'h5;
                    s_next.st = (req.op == pfc_pkg::PFC_OP_READ) ?
                        PFC_READ : PFC_SETUP;
                    s_next.cnt = pfc_pkg::CNT_ZERO;
                end
            end
            PFC_SETUP: begin
                // address settles with select low before the strobe falls
                s_next.pins.ce_n = 1'b0;
                s_next.pins.oe_n = 1'b1;
                s_next.pins.addr = cyc_addr;
                s_next.pins.dout = cyc_data;
                s_next.pins.dout_en = 1'b1;
                s_next.pins.we_n = 1'b1;
                s_next.cnt = pfc_pkg::CNT_ZERO;
                s_next.st = PFC_STROBE;
            end
            PFC_STROBE: begin
                // strobe falls one cycle after select and address settle
                s_next.pins.we_n = 1'b0;
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt == pfc_pkg::CNT_W'(pfc_pkg::STROBE_CYC)) begin
                    // data held past the rising edge, released in gap
                    s_next.pins.we_n = 1'b1;
                    s_next.cnt = pfc_pkg::CNT_ZERO;
                    s_next.st = PFC_GAP;
                end
            end
            PFC_GAP: begin
                s_next.pins.dout_en = 1'b0;
                s_next.pins.ce_n = 1'b1;
                if (s_reg.step == s_reg.nsteps) begin
                    s_next.st = PFC_READ;
                end else begin
                    s_next.step = s_reg.step + 3'h1;
                    s_next.st = PFC_SETUP;
                end
            end
            PFC_READ: begin
                // drive only reads while busy: bus floated by us
                s_next.pins.dout_en = 1'b0;
                s_next.pins.ce_n = 1'b0;
                s_next.pins.oe_n = 1'b0;
                s_next.pins.we_n = 1'b1;
                s_next.pins.addr = s_reg.addr;
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt == pfc_pkg::CNT_W'(pfc_pkg::ACCESS_CYC)) begin
                    s_next.cnt = pfc_pkg::CNT_ZERO;
                    s_next.st = PFC_EVAL;
                end
            end
            PFC_EVAL: begin
                s_next.pins.oe_n = 1'b1;
                s_next.pins.ce_n = 1'b1;
                s_next.prev = data_bus_in;
                s_next.have_prev = 1'b1;
                s_next.wait_cnt = s_reg.wait_cnt + 1'b1;
                s_next.st = PFC_READ;
                if (!s_reg.polling) begin
                    s_next.rsp.rdata = data_bus_in;
                    s_next.st = PFC_DONE;
                end else if (s_reg.have_prev && !toggling && bit7_ok) begin
                    // completion taken only after two clean re-reads
                    s_next.confirm = s_reg.confirm + 2'h1;
                    if (s_reg.confirm == 2'h2) begin
                        s_next.rsp.rdata = data_bus_in;
                        s_next.st = PFC_DONE;
                    end
                end else begin
                    s_next.confirm = 2'h0;
                    if (s_reg.wait_cnt >=
                            pfc_pkg::CNT_W'(POLL_LIMIT)) begin
                        s_next.rsp.error = 1'b1;
                        s_next.rsp.done = 1'b1;
                        s_next.st = PFC_IDLE;
                    end
                end
            end
            PFC_DONE: begin
                // flash back in read mode, next command may follow
                s_next.rsp.done = 1'b1;
                s_next.st = PFC_IDLE;
            end
            default: s_next.st = PFC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.st <= PFC_IDLE;
            s_reg.pins.ce_n <= 1'b1;
            s_reg.pins.oe_n <= 1'b1;
            s_reg.pins.we_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready = s_reg.ready;
    assign rsp = s_reg.rsp;
    assign pins = s_reg.pins;

    ////////////////////////////////////////////////////////////////////////
    a_no_drive_on_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(pins.dout_en && !pins.oe_n))
        else $error("host drives data bus while output gate low");
    a_strobe_needs_sel: assert property (
        @(posedge clk) disable iff (sys_rst)
        !pins.we_n |-> !pins.ce_n && pins.oe_n)
        else $error("write strobe without select");
    a_addr_before_strobe: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(pins.we_n) |-> !$past(pins.ce_n) && $stable(pins.addr))
        else $error("address or select not settled before strobe");
    a_data_held_edge: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(pins.we_n) |-> pins.dout_en)
        else $error("data released before strobe rise");
    a_done_one_cycle: assert property (
        @(posedge clk) disable iff (sys_rst)
        rsp.done |=> !rsp.done)
        else $error("done longer than one cycle");
    a_confirm_twice: assert property (
        @(posedge clk) disable iff (sys_rst)
        (s_reg.st == PFC_DONE && s_reg.polling) |-> s_reg.confirm == 2'h3)
        else $error("completion without two re-reads");
    a_unlock_first: assert property (
        @(posedge clk) disable iff (sys_rst)
        (s_reg.st == PFC_SETUP && s_reg.step == 3'h0) |=>
        pins.addr[14:0] == 15'h5555 && pins.dout == 8'haa)
        else $error("first unlock cycle wrong");
    a_prog_target: assert property (
        @(posedge clk) disable iff (sys_rst)
        (s_reg.st == PFC_SETUP && s_reg.step == 3'h3 &&
        s_reg.op == pfc_pkg::PFC_OP_PROGRAM) |=>
        pins.addr == s_reg.addr && pins.dout == s_reg.data)
        else $error("program target cycle wrong");
endmodule

// file: bench/pfc_flash_model.sv
`timescale 1ns/1ps
module pfc_flash_model #(
    parameter int PROG_NS = 2000,
    parameter int ERASE_NS = 3000
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [18:0] addr,
    input wire logic [7:0] din,
    input wire logic stuck,
    output logic [7:0] dq,
    output logic dq_en
);
    logic [7:0] mem [0:524287];
    logic [7:0] pdata = 8'h00;
    logic [7:0] last = 8'h00;
    logic [18:0] la = 19'h00000;
    logic busy = 1'b0;
    logic erasing = 1'b0;
    logic tog = 1'b0;
    int step = 0;
    int nwr = 0;
    wire wr_n = ce_n | we_n;
    wire rd_n = ce_n | oe_n;
    // low bits during busy are don't-care for the host
    wire [7:0] rd = !busy ? mem[addr] :
        {erasing ? 1'b0 : ~pdata[7], tog, mem[addr][5:0]};
    assign dq_en = !rd_n;
    // released bus shows the inverse so a stale byte never passes
    assign dq = dq_en ? rd : ~last;
    initial for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
    always @(posedge rd_n) last = rd;
    always @(negedge rd_n) if (busy) tog = ~tog;
    always @(negedge wr_n) la = addr;
    always @(posedge wr_n) begin
        nwr++;
        if (!busy) command(din);
    end

    task automatic run(input int ns, input logic er);
        busy = 1'b1;
        erasing = er;
        fork
            begin
                #ns;
                wait (!stuck);
                busy = 1'b0;
            end
        join_none
    endtask

    task automatic command(input logic [7:0] d);
        logic [14:0] a;
        a = la[14:0];
        if (step == 6) begin
            mem[la] = mem[la] & d;
            pdata = d;
            step = 0;
            run(PROG_NS, 1'b0);
        end else if (step == 5 && d == 8'h30) begin
            for (int i = 0; i < 4096; i++) mem[{la[18:12], i[11:0]}] = 8'hff;
            step = 0;
            run(ERASE_NS, 1'b1);
        end else if (step == 5 && a == 15'h5555 && d == 8'h10) begin
            for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
            step = 0;
            run(ERASE_NS, 1'b1);
        end else if (step == 2 && a == 15'h5555 && d inside {8'ha0, 8'h80})
            step = (d == 8'ha0) ? 6 : 3;
        else if ((step inside {0, 3} && a == 15'h5555 && d == 8'haa) ||
                 (step inside {1, 4} && a == 15'h2aaa && d == 8'h55))
            step++;
        else
            step = 0;
    endtask
endmodule

// file: bench/pfc_host_bench.sv
`timescale 1ns/1ps
module pfc_host_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic stuck = 1'b0;
    pfc_pkg::pfc_req_t req = '0;
    logic req_ready;
    pfc_pkg::pfc_rsp_t rsp;
    pfc_pkg::pfc_pins_t pins;
    logic [7:0] dq;
    logic dq_en;
    wire [7:0] bus = pins.dout_en ? pins.dout : dq;
    int fails = 0;
    int n_tests = 0;
    logic [7:0] got_rd;

    pfc_host #(.POLL_LIMIT(200)) pfc_host_inst (.clk(clk), .sys_rst(sys_rst),
        .req(req), .req_ready(req_ready), .rsp(rsp), .pins(pins),
        .data_bus_in(bus));
    pfc_flash_model pfc_flash_model_inst (.ce_n(pins.ce_n), .oe_n(pins.oe_n),
        .we_n(pins.we_n), .addr(pins.addr), .din(pins.dout), .stuck(stuck),
        .dq(dq), .dq_en(dq_en));

    initial forever #2.5 clk = ~clk;

    task chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one request, wait for completion, judge what is common to all ops
    task automatic op(input pfc_pkg::pfc_op_t o, input logic [18:0] a,
                      input logic [7:0] d, input int nw, input logic e);
        int n0;
        logic dn;
        n0 = pfc_flash_model_inst.nwr;
        dn = 1'b0;
        req <= '{1'b1, o, a, d};
        do @(posedge clk); while (req_ready !== 1'b1);
        req.valid <= 1'b0;
        for (int i = 0; i < 20000 && dn !== 1'b1; i++) begin
            @(posedge clk);
            dn = rsp.done;
        end
        chk1("done", 1'b1, dn);
        chk1("error", e, rsp.error);
        chk1("busy at done", e, pfc_flash_model_inst.busy);
        chk8("writes", 8'(nw), 8'(pfc_flash_model_inst.nwr - n0));
        got_rd = rsp.rdata;
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task test_reset;
        chk1("ce_n idle", 1'b1, pins.ce_n);
        chk1("we_n idle", 1'b1, pins.we_n);
        chk1("oe_n idle", 1'b1, pins.oe_n);
        chk1("dout_en idle", 1'b0, pins.dout_en);
        chk1("flash floats", 1'b0, dq_en);
        chk1("ready", 1'b1, req_ready);
        $display("test reset ended");
    endtask

    task test_program;
        // both polarities of bit 7 under data polling
        op(pfc_pkg::PFC_OP_PROGRAM, 19'h71234, 8'h5a, 4, 1'b0);
        op(pfc_pkg::PFC_OP_PROGRAM, 19'h00010, 8'ha5, 4, 1'b0);
        op(pfc_pkg::PFC_OP_READ, 19'h71234, 8'h00, 0, 1'b0);
        chk8("read prog a", 8'h5a, got_rd);
        op(pfc_pkg::PFC_OP_READ, 19'h00010, 8'h00, 0, 1'b0);
        chk8("read prog b", 8'ha5, got_rd);
        $display("test program ended");
    endtask

    task test_sector;
        op(pfc_pkg::PFC_OP_PROGRAM, 19'h12345, 8'h00, 4, 1'b0);
        op(pfc_pkg::PFC_OP_SECTOR_ERASE, 19'h12000, 8'h00, 6, 1'b0);
        op(pfc_pkg::PFC_OP_READ, 19'h12345, 8'h00, 0, 1'b0);
        chk8("erased byte", 8'hff, got_rd);
        op(pfc_pkg::PFC_OP_READ, 19'h71234, 8'h00, 0, 1'b0);
        chk8("other sector", 8'h5a, got_rd);
        $display("test sector erase ended");
    endtask

    task test_chip;
        op(pfc_pkg::PFC_OP_CHIP_ERASE, 19'h00000, 8'h00, 6, 1'b0);
        op(pfc_pkg::PFC_OP_READ, 19'h71234, 8'h00, 0, 1'b0);
        chk8("chip erased", 8'hff, got_rd);
        $display("test chip erase ended");
    endtask

    task test_timeout;
        stuck <= 1'b1;
        op(pfc_pkg::PFC_OP_PROGRAM, 19'h00020, 8'h3c, 4, 1'b1);
        stuck <= 1'b0;
        for (int i = 0; i < 2000 && pfc_flash_model_inst.busy; i++)
            @(posedge clk);
        op(pfc_pkg::PFC_OP_READ, 19'h00020, 8'h00, 0, 1'b0);
        chk8("after timeout", 8'h3c, got_rd);
        $display("test timeout ended");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        test_reset;
        test_program;
        test_sector;
        test_chip;
        test_timeout;
        test_done;
    end

    // all tests need roughly 6500 cycles
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule
